// ### nfcmc_mode_control.sv
// contactless front end coding, start-up sequence and transmitter drive
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - vicinity mode downlink reference interval is 9.44 us or 18.88 us
// - vicinity replies decode as four- or two-pulse subcarrier Manchester
// - vicinity subcarrier is carrier/32 when selector 0, carrier/16 when 1
// - peer active and passive modes run at 106, 212 and 424 kbit/s
// - 106 uses Type A coding; 212 and 424 use Manchester coding
// - initiator: Manchester partial ASK above 106, modified Miller full ASK
// - passive target above 106 answers Manchester load modulation
// - card emulation answers by load modulation, never its own carrier
// - card emulation decodes 128-cycle Miller, answers on carrier/16
// - bit rate stays fixed for a whole transaction
// - after reset the block is target with its field off
// - field level detector stays enabled while target
// - initiator role is entered only on software request
// - initiator field turns on only after a quiet period without external field
// - initiator starts its exchange only once its field is on
// - active mode uses own field both ways; passive target load modulates
// - both antenna drives carry carrier gated by the coded envelope
// - a setting picks which antenna drive carries the inverted carrier
// - envelope supports full-depth and several partial modulation levels
// - programmable overshoot and undershoot pulses shape the drive edges
module nfcmc_mode_control #(
	parameter logic [23:0] QUIET_DEFAULT = nfcmc_pkg::QUIET_RST
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic carrierIn,
	input wire logic extFieldIn,
	input wire logic rxMarkIn,
	input wire logic txValid,
	input wire logic txBit,
	output logic txReady,
	output logic rxBit,
	output logic rxValid,
	output logic rxEnd,
	output logic antennaDriveP,
	output logic antennaDriveN,
	output logic [5:0] envelopeLevel,
	output logic loadModulate,
	output logic rfFieldEnable,
	output logic fieldDetectEnable,
	output logic overshootPulse,
	output logic undershootPulse
);
	nfcmc_link_if link ();

	logic [1:0] carrierSync_reg;
	logic [1:0] extSync_reg;
	logic [1:0] markSync_reg;
	logic carrierPrev_reg;
	logic carrierLvl;
	logic carrierTick;
	logic extField;

	logic txnActive_reg;
	logic invertP_reg;
	logic [nfcmc_pkg::CFG_W-1:0] cfg_reg;
	logic [nfcmc_pkg::CFG_W-1:0] applied_reg;
	logic [23:0] quiet_reg;
	logic [15:0] shape_reg;
	logic [31:0] regRdata_reg;
	logic [31:0] readMux;
	logic wrCtrl;
	logic initReq;
	logic targetReq;

	nfcmc_pkg::nfcmc_role_t role_reg;
	logic [23:0] quietCnt_reg;
	logic quietDone;

	logic [1:0] mode;
	logic [1:0] rate;
	logic divSel;
	logic tariLong;
	logic twoPulse;
	logic [1:0] amSel;
	logic [5:0] phaseDiv;
	logic [5:0] carrierCnt_reg;
	logic phaseTick;
	logic [nfcmc_pkg::SUB_CNT_W-1:0] subCnt_reg;
	logic [10:0] tariQuarter;
	logic [10:0] tariCnt_reg;
	logic tariTick;
	logic txAllow;
	logic fullDepth;

	logic rfOn_reg;
	logic [5:0] envLevel_reg;
	logic loadMod_reg;
	logic driveP_reg;
	logic driveN_reg;
	logic detEn_reg;
	logic modPrev_reg;
	logic [7:0] overCnt_reg;
	logic [7:0] underCnt_reg;

	// pin inputs pass two flops before any logic looks at them
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			carrierSync_reg <= 2'h0;
			extSync_reg <= 2'h0;
			markSync_reg <= 2'h0;
			carrierPrev_reg <= 1'b0;
		end else begin
			carrierSync_reg <= {carrierSync_reg[0], carrierIn};
			extSync_reg <= {extSync_reg[0], extFieldIn};
			markSync_reg <= {markSync_reg[0], rxMarkIn};
			carrierPrev_reg <= carrierSync_reg[1];
		end
	end

	assign carrierLvl = carrierSync_reg[1];
	assign carrierTick = carrierLvl && !carrierPrev_reg;
	assign extField = extSync_reg[1];

	assign wrCtrl = regWrite && regAddr == nfcmc_pkg::OFS_CTRL;
	assign initReq = wrCtrl && regWdata[nfcmc_pkg::CTRL_INIT_BIT];
	assign targetReq = wrCtrl && regWdata[nfcmc_pkg::CTRL_TARGET_BIT];

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			txnActive_reg <= 1'b0;
			invertP_reg <= 1'b0;
			cfg_reg <= nfcmc_pkg::CFG_RST;
			quiet_reg <= QUIET_DEFAULT;
			shape_reg <= nfcmc_pkg::SHAPE_RST;
		end else if (regWrite) begin
			case (regAddr)
			nfcmc_pkg::OFS_CTRL: begin
				txnActive_reg <= regWdata[nfcmc_pkg::CTRL_TXN_BIT];
				invertP_reg <= regWdata[nfcmc_pkg::CTRL_INVP_BIT];
			end
			nfcmc_pkg::OFS_CFG: cfg_reg <= regWdata[nfcmc_pkg::CFG_W-1:0];
			nfcmc_pkg::OFS_QUIET: quiet_reg <= regWdata[23:0];
			nfcmc_pkg::OFS_SHAPE: shape_reg <= regWdata[15:0];
			default: cfg_reg <= cfg_reg;
			endcase
		end
	end

	// coding in use only follows the written copy between transactions
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			applied_reg <= nfcmc_pkg::CFG_RST;
		end else if (!txnActive_reg) begin
			applied_reg <= cfg_reg;
		end
	end

	assign mode = applied_reg[nfcmc_pkg::CFG_MODE_LSB +: 2];
	assign rate = (mode == nfcmc_pkg::MODE_CARD_A) ? nfcmc_pkg::RATE_106 :
		applied_reg[nfcmc_pkg::CFG_RATE_LSB +: 2];
	assign divSel = applied_reg[nfcmc_pkg::CFG_DIVSEL_BIT];
	assign tariLong = applied_reg[nfcmc_pkg::CFG_TARI_BIT];
	assign twoPulse = applied_reg[nfcmc_pkg::CFG_TWOP_BIT];
	assign amSel = applied_reg[nfcmc_pkg::CFG_AM_LSB +: 2];

	// start-up: target by default, initiator only on request after quiet
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			role_reg <= nfcmc_pkg::ROLE_TARGET;
		end else begin
			case (role_reg)
			nfcmc_pkg::ROLE_TARGET: begin
				if (initReq) begin
					role_reg <= nfcmc_pkg::ROLE_QUIET;
				end
			end
			nfcmc_pkg::ROLE_QUIET: begin
				if (targetReq) begin
					role_reg <= nfcmc_pkg::ROLE_TARGET;
				end else if (quietDone && !extField) begin
					role_reg <= nfcmc_pkg::ROLE_INIT;
				end
			end
			nfcmc_pkg::ROLE_INIT: begin
				if (targetReq) begin
					role_reg <= nfcmc_pkg::ROLE_TARGET;
				end
			end
			default: role_reg <= nfcmc_pkg::ROLE_TARGET;
			endcase
		end
	end

	// any external field restarts the quiet count
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			quietCnt_reg <= 24'h000000;
		end else if (role_reg != nfcmc_pkg::ROLE_QUIET || extField) begin
			quietCnt_reg <= 24'h000000;
		end else if (!quietDone) begin
			quietCnt_reg <= quietCnt_reg + 24'h000001;
		end
	end

	assign quietDone = quietCnt_reg >= quiet_reg;

	// phase timing: eight phases per bit, counted in carrier periods
	always_comb begin
		if (mode == nfcmc_pkg::MODE_VICINITY) begin
			case ({divSel, twoPulse})
			2'h0: phaseDiv = nfcmc_pkg::PH_DIV_S4;
			2'h1: phaseDiv = nfcmc_pkg::PH_DIV_S2;
			2'h2: phaseDiv = nfcmc_pkg::PH_DIV_F4;
			default: phaseDiv = nfcmc_pkg::PH_DIV_F2;
			endcase
		end else begin
			case (rate)
			nfcmc_pkg::RATE_106: phaseDiv = nfcmc_pkg::PH_DIV_106;
			nfcmc_pkg::RATE_212: phaseDiv = nfcmc_pkg::PH_DIV_212;
			default: phaseDiv = nfcmc_pkg::PH_DIV_424;
			endcase
		end
	end

	assign phaseTick = carrierTick && carrierCnt_reg >= phaseDiv - 6'h01;
	assign tariQuarter = tariLong ? nfcmc_pkg::TARI_Q_LONG_CYC :
		nfcmc_pkg::TARI_Q_SHORT_CYC;
	assign tariTick = tariCnt_reg >= tariQuarter - 11'h001;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			carrierCnt_reg <= 6'h00;
			subCnt_reg <= '0;
			tariCnt_reg <= 11'h000;
		end else begin
			if (carrierTick) begin
				carrierCnt_reg <= phaseTick ? 6'h00 : carrierCnt_reg + 6'h01;
				subCnt_reg <= subCnt_reg + 1'b1;
			end
			tariCnt_reg <= tariTick ? 11'h000 : tariCnt_reg + 11'h001;
		end
	end

	// coding per mode, rate and role
	always_comb begin
		case (mode)
		nfcmc_pkg::MODE_VICINITY: link.txCode = nfcmc_pkg::CODE_PIE;
		nfcmc_pkg::MODE_CARD_A: link.txCode = nfcmc_pkg::CODE_MANCH_SUB;
		nfcmc_pkg::MODE_PASSIVE: begin
			if (role_reg == nfcmc_pkg::ROLE_INIT) begin
				link.txCode = (rate == nfcmc_pkg::RATE_106) ?
					nfcmc_pkg::CODE_MILLER : nfcmc_pkg::CODE_MANCH_ASK;
			end else begin
				link.txCode = (rate == nfcmc_pkg::RATE_106) ?
					nfcmc_pkg::CODE_MANCH_SUB : nfcmc_pkg::CODE_MANCH_LM;
			end
		end
		default: link.txCode = (rate == nfcmc_pkg::RATE_106) ?
			nfcmc_pkg::CODE_MILLER : nfcmc_pkg::CODE_MANCH_ASK;
		endcase
	end

	// initiator-type transfers wait for the field, targets raise one only in active mode
	always_comb begin
		if (role_reg == nfcmc_pkg::ROLE_INIT) begin
			txAllow = mode != nfcmc_pkg::MODE_CARD_A;
		end else begin
			txAllow = role_reg == nfcmc_pkg::ROLE_TARGET &&
				mode != nfcmc_pkg::MODE_VICINITY;
		end
	end

	assign link.encTick = (mode == nfcmc_pkg::MODE_VICINITY) ? tariTick :
		phaseTick;
	assign link.subcarrier = subCnt_reg[nfcmc_pkg::SUB_CNT_W-1];
	assign link.txValid = txValid && txAllow;
	assign link.txBit = txBit;
	assign txReady = link.txTake;

	assign link.decTick = phaseTick;
	assign link.decManch = mode == nfcmc_pkg::MODE_VICINITY;
	assign link.decEn = mode == nfcmc_pkg::MODE_VICINITY ||
		mode == nfcmc_pkg::MODE_CARD_A ||
		(role_reg == nfcmc_pkg::ROLE_TARGET && rate == nfcmc_pkg::RATE_106);
	assign link.mark = markSync_reg[1];
	assign rxBit = link.rxBit;
	assign rxValid = link.rxValid;
	assign rxEnd = link.rxEnd;

	nfcmc_tx_encoder encoder (
		.core_clk(core_clk),
		.nrst(nrst),
		.link(link)
	);

	nfcmc_rx_decoder decoder (
		.core_clk(core_clk),
		.nrst(nrst),
		.link(link)
	);

	assign fullDepth = link.txCode == nfcmc_pkg::CODE_MILLER ||
		link.txCode == nfcmc_pkg::CODE_PIE;

	// field, envelope and load modulation
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rfOn_reg <= 1'b0;
			envLevel_reg <= nfcmc_pkg::LEVEL_OFF;
			loadMod_reg <= 1'b0;
			detEn_reg <= 1'b1;
		end else begin
			rfOn_reg <= (role_reg == nfcmc_pkg::ROLE_INIT &&
				mode != nfcmc_pkg::MODE_CARD_A) ||
				(role_reg == nfcmc_pkg::ROLE_TARGET &&
				mode == nfcmc_pkg::MODE_ACTIVE && link.encBusy);
			detEn_reg <= role_reg != nfcmc_pkg::ROLE_INIT;
			loadMod_reg <= link.loadMod;
			if (!rfOn_reg) begin
				envLevel_reg <= nfcmc_pkg::LEVEL_OFF;
			end else if (link.modActive) begin
				envLevel_reg <= fullDepth ? nfcmc_pkg::LEVEL_OFF :
					nfcmc_pkg::AM_LEVELS[amSel];
			end else begin
				envLevel_reg <= nfcmc_pkg::LEVEL_FULL;
			end
		end
	end

	// carrier gated by the envelope; one drive carries the inverted carrier
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			driveP_reg <= 1'b0;
			driveN_reg <= 1'b0;
		end else begin
			driveP_reg <= (envLevel_reg != nfcmc_pkg::LEVEL_OFF) &&
				(carrierLvl ^ invertP_reg);
			driveN_reg <= (envLevel_reg != nfcmc_pkg::LEVEL_OFF) &&
				(carrierLvl ^ !invertP_reg);
		end
	end

	// shaping pulses after each edge of the modulation request
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			modPrev_reg <= 1'b0;
			overCnt_reg <= 8'h00;
			underCnt_reg <= 8'h00;
		end else begin
			modPrev_reg <= link.modActive;
			if (modPrev_reg && !link.modActive) begin
				overCnt_reg <= shape_reg[7:0];
			end else if (overCnt_reg != 8'h00) begin
				overCnt_reg <= overCnt_reg - 8'h01;
			end
			if (!modPrev_reg && link.modActive) begin
				underCnt_reg <= shape_reg[15:8];
			end else if (underCnt_reg != 8'h00) begin
				underCnt_reg <= underCnt_reg - 8'h01;
			end
		end
	end

	always_comb begin
		case (regAddr)
		nfcmc_pkg::OFS_CTRL: readMux = {28'h0000000, invertP_reg,
			txnActive_reg, 2'h0};
		nfcmc_pkg::OFS_CFG: readMux = {23'h000000, cfg_reg};
		nfcmc_pkg::OFS_QUIET: readMux = {8'h00, quiet_reg};
		nfcmc_pkg::OFS_SHAPE: readMux = {16'h0000, shape_reg};
		nfcmc_pkg::OFS_STATUS: readMux = {26'h0000000, detEn_reg,
			link.encBusy, extField, rfOn_reg, role_reg};
		nfcmc_pkg::OFS_APPLIED: readMux = {23'h000000, applied_reg};
		default: readMux = 32'h00000000;
		endcase
	end

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			regRdata_reg <= 32'h00000000;
		end else begin
			regRdata_reg <= regRead ? readMux : 32'h00000000;
		end
	end

	assign regRdata = regRdata_reg;
	assign antennaDriveP = driveP_reg;
	assign antennaDriveN = driveN_reg;
	assign envelopeLevel = envLevel_reg;
	assign loadModulate = loadMod_reg;
	assign rfFieldEnable = rfOn_reg;
	assign fieldDetectEnable = detEn_reg;
	assign overshootPulse = overCnt_reg != 8'h00;
	assign undershootPulse = underCnt_reg != 8'h00;
endmodule : nfcmc_mode_control

// ### nfcmc_pkg.sv
// constants, register map and types shared by the mode coding control files
package nfcmc_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_QUIET = 8'h08;
	localparam logic [7:0] OFS_SHAPE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_APPLIED = 8'h14;

	localparam int CTRL_INIT_BIT = 0;
	localparam int CTRL_TARGET_BIT = 1;
	localparam int CTRL_TXN_BIT = 2;
	localparam int CTRL_INVP_BIT = 3;

	localparam int CFG_W = 9;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_RATE_LSB = 2;
	localparam int CFG_DIVSEL_BIT = 4;
	localparam int CFG_TARI_BIT = 5;
	localparam int CFG_TWOP_BIT = 6;
	localparam int CFG_AM_LSB = 7;
	localparam logic [8:0] CFG_RST = 9'h000;
	localparam logic [23:0] QUIET_RST = 24'h1312D0;
	localparam logic [15:0] SHAPE_RST = 16'h0000;

	localparam logic [1:0] MODE_ACTIVE = 2'h0;
	localparam logic [1:0] MODE_PASSIVE = 2'h1;
	localparam logic [1:0] MODE_CARD_A = 2'h2;
	localparam logic [1:0] MODE_VICINITY = 2'h3;
	localparam logic [1:0] RATE_106 = 2'h0;
	localparam logic [1:0] RATE_212 = 2'h1;

	localparam int CORE_CLK_MHZ = 250;
	localparam int TARI_SHORT_NS = 9440;
	localparam int TARI_LONG_NS = 18880;
	localparam int TARI_PHASES = 4;
	localparam logic [10:0] TARI_Q_SHORT_CYC =
		11'(TARI_SHORT_NS * CORE_CLK_MHZ / (1000 * TARI_PHASES));
	localparam logic [10:0] TARI_Q_LONG_CYC =
		11'(TARI_LONG_NS * CORE_CLK_MHZ / (1000 * TARI_PHASES));

	localparam int PHASES_PER_BIT = 8;
	localparam int HALF_PHASES = PHASES_PER_BIT / 2;
	localparam int BIT_106_CARRIER = 128;
	localparam logic [5:0] PH_DIV_106 = 6'(BIT_106_CARRIER / PHASES_PER_BIT);
	localparam logic [5:0] PH_DIV_212 = 6'(BIT_106_CARRIER / 2 / PHASES_PER_BIT);
	localparam logic [5:0] PH_DIV_424 = 6'(BIT_106_CARRIER / 4 / PHASES_PER_BIT);
	localparam int SUB_SLOW_DIV = 32;
	localparam int SUB_FAST_DIV = 16;
	localparam int PULSES_FOUR = 4;
	localparam int PULSES_TWO = 2;
	localparam logic [5:0] PH_DIV_S4 = 6'(PULSES_FOUR * SUB_SLOW_DIV / HALF_PHASES);
	localparam logic [5:0] PH_DIV_S2 = 6'(PULSES_TWO * SUB_SLOW_DIV / HALF_PHASES);
	localparam logic [5:0] PH_DIV_F4 = 6'(PULSES_FOUR * SUB_FAST_DIV / HALF_PHASES);
	localparam logic [5:0] PH_DIV_F2 = 6'(PULSES_TWO * SUB_FAST_DIV / HALF_PHASES);
	localparam int CARD_SUB_DIV = 16;
	localparam int SUB_CNT_W = $clog2(CARD_SUB_DIV);
	localparam logic [2:0] PHASE_LAST = 3'h7;
	localparam logic [2:0] PIE_ZERO_LAST = 3'h3;

	localparam logic [5:0] LEVEL_FULL = 6'h3F;
	localparam logic [5:0] LEVEL_OFF = 6'h00;
	localparam logic [5:0] AM_LEVELS [4] = '{6'h3A, 6'h36, 6'h32, 6'h2C};

	typedef enum logic [1:0] {
		ROLE_TARGET = 2'b00,
		ROLE_QUIET = 2'b01,
		ROLE_INIT = 2'b10
	} nfcmc_role_t;

	typedef enum logic [2:0] {
		CODE_MILLER = 3'b000,
		CODE_MANCH_ASK = 3'b001,
		CODE_MANCH_LM = 3'b010,
		CODE_MANCH_SUB = 3'b011,
		CODE_PIE = 3'b100
	} nfcmc_code_t;
endpackage : nfcmc_pkg

// ### nfcmc_link_if.sv
// signals shared between the controller, the encoder and the decoder
`timescale 1ns/1ps
interface nfcmc_link_if;
	logic encTick;
	logic decTick;
	logic subcarrier;
	nfcmc_pkg::nfcmc_code_t txCode;
	logic txValid;
	logic txBit;
	logic txTake;
	logic encBusy;
	logic modActive;
	logic loadMod;
	logic decEn;
	logic decManch;
	logic mark;
	logic rxBit;
	logic rxValid;
	logic rxEnd;

	modport enc(input encTick, input subcarrier, input txCode, input txValid,
		input txBit, output txTake, output encBusy, output modActive,
		output loadMod);
	modport dec(input decTick, input decEn, input decManch, input mark,
		output rxBit, output rxValid, output rxEnd);
endinterface : nfcmc_link_if

// ### nfcmc_tx_encoder.sv
// bit-serial encoder turning data bits into modulation requests
`timescale 1ns/1ps
module nfcmc_tx_encoder (
	input wire logic core_clk,
	input wire logic nrst,
	nfcmc_link_if.enc link
);
	logic busy_reg;
	logic [2:0] phase_reg;
	logic bit_reg;
	logic prev_reg;
	logic [2:0] lastPhase;
	logic atLast;
	logic firstHalf;

	// a data-0 interval symbol spans half the phases of a data-1
	assign lastPhase = (link.txCode == nfcmc_pkg::CODE_PIE && !bit_reg) ?
		nfcmc_pkg::PIE_ZERO_LAST : nfcmc_pkg::PHASE_LAST;
	assign atLast = busy_reg && phase_reg == lastPhase;
	assign link.txTake = link.encTick && link.txValid && (!busy_reg || atLast);
	assign link.encBusy = busy_reg;
	assign firstHalf = !phase_reg[2];

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
			phase_reg <= 3'h0;
			bit_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else if (link.txTake) begin
			busy_reg <= 1'b1;
			phase_reg <= 3'h0;
			bit_reg <= link.txBit;
			prev_reg <= busy_reg ? bit_reg : 1'b0;
		end else if (link.encTick && busy_reg) begin
			busy_reg <= !atLast;
			phase_reg <= phase_reg + 3'h1;
		end
	end

	always_comb begin
		link.modActive = 1'b0;
		link.loadMod = 1'b0;
		if (busy_reg) begin
			case (link.txCode)
			nfcmc_pkg::CODE_MILLER: link.modActive = bit_reg ?
				(phase_reg[2:1] == 2'h2) : (!prev_reg && phase_reg[2:1] == 2'h0);
			nfcmc_pkg::CODE_MANCH_ASK: link.modActive = bit_reg == firstHalf;
			nfcmc_pkg::CODE_MANCH_LM: link.loadMod = bit_reg == firstHalf;
			nfcmc_pkg::CODE_MANCH_SUB: link.loadMod =
				(bit_reg == firstHalf) && link.subcarrier;
			nfcmc_pkg::CODE_PIE: link.modActive = phase_reg[2:1] == lastPhase[2:1];
			default: link.modActive = 1'b0;
			endcase
		end
	end
endmodule : nfcmc_tx_encoder

// ### nfcmc_rx_decoder.sv
// frame decoder for pause-coded and subcarrier-coded incoming bits
`timescale 1ns/1ps
module nfcmc_rx_decoder (
	input wire logic core_clk,
	input wire logic nrst,
	nfcmc_link_if.dec link
);
	logic active_reg;
	logic [2:0] phase_reg;
	logic markA_reg;
	logic markB_reg;
	logic prevBit_reg;
	logic secondSeen;
	logic bitValue;
	logic endFrame;

	assign secondSeen = markB_reg | link.mark;

	always_comb begin
		if (link.decManch) begin
			bitValue = markA_reg;
			endFrame = !markA_reg && !secondSeen;
		end else begin
			// pause late in the bit is a one, early or absent is a zero
			bitValue = secondSeen;
			endFrame = !markA_reg && !secondSeen && !prevBit_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst || !link.decEn) begin
			active_reg <= 1'b0;
			phase_reg <= 3'h0;
			markA_reg <= 1'b0;
			markB_reg <= 1'b0;
			prevBit_reg <= 1'b0;
			link.rxBit <= 1'b0;
			link.rxValid <= 1'b0;
			link.rxEnd <= 1'b0;
		end else begin
			link.rxValid <= 1'b0;
			link.rxEnd <= 1'b0;
			if (link.decTick) begin
				if (!active_reg) begin
					// first mark aligns the bit grid and opens the frame
					active_reg <= link.mark;
					phase_reg <= link.mark ? 3'h1 : 3'h0;
					markA_reg <= link.mark;
					markB_reg <= 1'b0;
					prevBit_reg <= 1'b1;
				end else if (phase_reg == nfcmc_pkg::PHASE_LAST) begin
					phase_reg <= 3'h0;
					markA_reg <= 1'b0;
					markB_reg <= 1'b0;
					active_reg <= !endFrame;
					link.rxEnd <= endFrame;
					link.rxValid <= !endFrame;
					link.rxBit <= bitValue;
					prevBit_reg <= bitValue;
				end else begin
					phase_reg <= phase_reg + 3'h1;
					if (!phase_reg[2]) begin
						markA_reg <= markA_reg | link.mark;
					end else begin
						markB_reg <= markB_reg | link.mark;
					end
				end
			end
		end
	end
endmodule : nfcmc_rx_decoder

// ### nfcmc_mode_control_checker.sv
// port assertions for the mode coding control block
`timescale 1ns/1ps
module nfcmc_mode_control_checker #(
	parameter logic [23:0] QUIET_DEFAULT = 24'h000010
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	input wire logic extFieldIn,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic rxValid,
	input wire logic antennaDriveP,
	input wire logic antennaDriveN,
	input wire logic [5:0] envelopeLevel,
	input wire logic loadModulate,
	input wire logic rfFieldEnable,
	input wire logic fieldDetectEnable
);
	logic [31:0] quietCnt_reg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// cycles the raw detector has been low
	always_ff @(posedge core_clk) begin
		if (!nrst || extFieldIn)
			quietCnt_reg <= 32'h0;
		else
			quietCnt_reg <= quietCnt_reg + 32'h1;
	end
	a_read_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
		else $error("read data not zero outside read cycle");
	a_field_after_quiet: assert property ($rose(rfFieldEnable) |->
		quietCnt_reg >= 32'(QUIET_DEFAULT)) else $error("field on too early");
	a_detect_target: assert property (!fieldDetectEnable |->
		(##[0:1] rfFieldEnable) or $past(rfFieldEnable))
		else $error("detector off outside initiator");
	a_reset_state: assert property ($rose(nrst) |-> !rfFieldEnable &&
		fieldDetectEnable && envelopeLevel == 6'h00)
		else $error("wrong state after reset");
	// the drives follow the envelope one cycle later
	a_drive_gated: assert property ($past(envelopeLevel) == 6'h00 |->
		!antennaDriveP && !antennaDriveN) else $error("drive without envelope");
	a_drive_invert: assert property ($past(envelopeLevel) != 6'h00 |->
		antennaDriveP != antennaDriveN) else $error("drives not inverted");
	a_load_no_field: assert property (loadModulate |-> !rfFieldEnable)
		else $error("load modulation with own field");
	a_tx_handshake: assert property (txReady |-> txValid ##1 !txReady)
		else $error("bad take pulse");
	a_rx_pulse: assert property (rxValid |=> !rxValid)
		else $error("rx valid longer than one cycle");
endmodule : nfcmc_mode_control_checker

bind nfcmc_mode_control nfcmc_mode_control_checker #(
	.QUIET_DEFAULT(QUIET_DEFAULT)) chk (.core_clk, .nrst, .regRead, .regRdata,
	.extFieldIn, .txValid, .txReady, .rxValid, .antennaDriveP, .antennaDriveN,
	.envelopeLevel, .loadModulate, .rfFieldEnable, .fieldDetectEnable);

// ### nfcmc_peer_model.sv
// remote reader or peer: field, carrier and reader pauses
`timescale 1ns/1ps
module nfcmc_peer_model (
	input wire logic devField,
	input wire logic fieldOn,
	output logic carrierIn,
	output logic extFieldIn,
	output logic rxMarkIn
);
	initial begin
		carrierIn = 1'b0;
		rxMarkIn = 1'b0;
	end
	assign extFieldIn = fieldOn;
	// carrier only runs while some field is up
	always #80 if (fieldOn || devField || carrierIn) carrierIn = ~carrierIn;
	// one reader bit, 128 carrier cycles, pause in the chosen half
	task automatic millerBit(input logic one, input logic pause);
		for (int p = 0; p < 8; p++) begin
			rxMarkIn = pause && (p == (one ? 4 : 0) || p == (one ? 5 : 1));
			repeat (16) @(posedge carrierIn);
		end
		rxMarkIn = 1'b0;
	endtask : millerBit
endmodule : nfcmc_peer_model

// ### nfcmc_mode_control_tb.sv
// self-checking bench for the mode coding control block
`timescale 1ns/1ps
module nfcmc_mode_control_tb;
	logic core_clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic txValid = 1'b0, txBit = 1'b0, fieldOn = 1'b0, clrMin = 1'b0;
	logic [7:0] regAddr = 8'h00, rxSeen = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	logic carrierIn, extFieldIn, rxMarkIn, txReady, rxBit, rxValid, rxEnd;
	logic antennaDriveP, antennaDriveN, loadModulate, rfFieldEnable;
	logic fieldDetectEnable, sawLoad = 1'b0, endSeen = 1'b0;
	logic overshootPulse, undershootPulse;
	logic [31:0] zeroCyc = 32'h0, overCyc = 32'h0, underCyc = 32'h0;
	logic [5:0] envelopeLevel, minEnv = 6'h3F;
	// last two entries: vicinity downlink, short and long reference interval
	logic [31:0] cfgs [5] = '{32'h001, 32'h185, 32'h009, 32'h003, 32'h023};
	logic [31:0] envs [5] = '{32'h00, 32'h2C, 32'h3A, 32'h00, 32'h00};
	// full-depth cycles: two 106 phases, or two quarters per vicinity bit
	logic [31:0] pauses [5] = '{32'h500, 32'h0, 32'h0, 32'h938, 32'h1270};
	int errors = 0, num_checks = 0, rxCount = 0;
	always #2 core_clk = ~core_clk;
	nfcmc_mode_control #(.QUIET_DEFAULT(24'h000010)) dut (.core_clk, .nrst,
		.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .carrierIn,
		.extFieldIn, .rxMarkIn, .txValid, .txBit, .txReady, .rxBit, .rxValid,
		.rxEnd, .antennaDriveP, .antennaDriveN, .envelopeLevel, .loadModulate,
		.rfFieldEnable, .fieldDetectEnable, .overshootPulse,
		.undershootPulse);
	nfcmc_peer_model peer (.devField(rfFieldEnable), .fieldOn, .carrierIn,
		.extFieldIn, .rxMarkIn);
	always @(posedge core_clk) begin
		if (rxValid === 1'b1) begin
			rxSeen <= {rxSeen[6:0], rxBit};
			rxCount <= rxCount + 1;
		end
		if (rxEnd === 1'b1) endSeen <= 1'b1;
		if (loadModulate === 1'b1) sawLoad <= 1'b1;
		if (clrMin) begin
			minEnv <= 6'h3F;
			zeroCyc <= 32'h0;
			overCyc <= 32'h0;
			underCyc <= 32'h0;
		end else begin
			if (envelopeLevel < minEnv) minEnv <= envelopeLevel;
			if (envelopeLevel === 6'h00) zeroCyc <= zeroCyc + 32'h1;
			if (overshootPulse === 1'b1) overCyc <= overCyc + 32'h1;
			if (undershootPulse === 1'b1) underCyc <= underCyc + 32'h1;
		end
	end
	task automatic summarize();
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic waitHi(ref logic s, input int lim);
		for (int i = 0; i < lim; i++) begin
			tick(1);
			if (s === 1'b1) return;
		end
		check(32'h0, 32'h1);
		summarize();
	endtask : waitHi
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		tick(1);
		regWrite <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		tick(1);
		regRead <= 1'b0;
		#1 check(regRdata, exp);
		tick(1);
	endtask : rdchk
	task automatic sendBit(input logic b);
		txValid <= 1'b1;
		txBit <= b;
		waitHi(txReady, 12000);
	endtask : sendBit
	initial begin
		tick(16);
		nrst <= 1'b1;
		tick(2);
		rdchk(8'h04, 32'h0);
		rdchk(8'h08, 32'h10);
		rdchk(8'h10, 32'h20);
		wr(8'h18, 32'hFFFF);
		rdchk(8'h18, 32'h0);
		wr(8'h0C, 32'h0302);
		rdchk(8'h0C, 32'h0302);
		wr(8'h00, 32'h4);
		wr(8'h04, 32'h5);
		rdchk(8'h04, 32'h5);
		rdchk(8'h14, 32'h0);
		wr(8'h00, 32'h0);
		rdchk(8'h14, 32'h5);
		tick(100);
		rdchk(8'h10, 32'h20);
		fieldOn <= 1'b1;
		wr(8'h00, 32'h1);
		tick(60);
		rdchk(8'h10, 32'h29);
		fieldOn <= 1'b0;
		waitHi(rfFieldEnable, 100);
		rdchk(8'h10, 32'h06);
		for (int k = 0; k < 5; k++) begin
			wr(8'h04, cfgs[k]);
			clrMin <= 1'b1;
			tick(1);
			clrMin <= 1'b0;
			sendBit(1'b1);
			sendBit(1'b0);
			txValid <= 1'b0;
			tick(6000);
			check(32'(minEnv), envs[k]);
			check(zeroCyc, pauses[k]);
			// one pause edge pair for the Miller bits, two pairs otherwise
			check(overCyc, (k == 0) ? 32'h2 : 32'h4);
			check(underCyc, (k == 0) ? 32'h3 : 32'h6);
		end
		wr(8'h00, 32'h2);
		wr(8'h04, 32'h2);
		fieldOn <= 1'b1;
		tick(200);
		peer.millerBit(1'b0, 1'b1);
		peer.millerBit(1'b1, 1'b1);
		peer.millerBit(1'b0, 1'b0);
		peer.millerBit(1'b0, 1'b0);
		tick(2000);
		check(32'(rxCount), 32'h3);
		check(32'(rxSeen[2:0]), 32'h2);
		check(32'(endSeen), 32'h1);
		sendBit(1'b1);
		txValid <= 1'b0;
		tick(6000);
		check(32'(sawLoad), 32'h1);
		check(32'(rfFieldEnable), 32'h0);
		summarize();
	end
endmodule : nfcmc_mode_control_tb
